// ===== rtl/didel_top.sv
// device identity, fault summary and fault history objects behind an object access port
// Operation
// RQ1: identity bits 23..16 give motor kinds: 2 BLDC, 4 stepper, 6 both.
// RQ2: identity low sixteen bits hold the fixed device profile number.
// RQ3: summary category bit follows its fault, clearing itself when the fault ends.
// RQ4: summary bits: 0 general,1 current,2 voltage,3 temperature,4 comm,5 profile,7 maker; 6 zero.
// RQ5: every fault occurrence logs a detailed code into the history.
// RQ6: history keeps up to eight 32-bit codes at sub-positions 1 to 8.
// RQ7: new code enters position 1; older entries shift back, the last drops off.
// RQ8: sub-position 0 returns the number of faults logged.
// RQ9: reads of positions 1 to 8 with empty history abort with 08000024.
// RQ10: writing zero to the count restarts counting; history treated as empty.
// RQ11: count is 8-bit read/write preset zero; entries read-only 32-bit preset zero.
// RQ12: writes to read-only objects are refused.
// RQ13: count saturates at eight; nonzero writes to the count abort.
`timescale 1ns/1ps
`include "didel_defs.svh"
module didel_top
   import didel_pkg::*;
#(
   parameter didel_motors_t MOTORS = DIDEL_MOTORS_BOTH,
   parameter logic [15:0] PROFILE = `DIDEL_PROFILE_DEFAULT,
   parameter int DEPTH = `DIDEL_HISTORY_DEPTH
) (
   input wire logic clk_sys,
   input wire logic arst_n,
   input wire logic [7:0] fault_active,
   input wire logic fault_log,
   input wire logic [31:0] fault_code,
   input wire logic req_valid,
   input wire logic req_write,
   input wire logic [15:0] req_index,
   input wire logic [7:0] req_sub,
   input wire logic [31:0] req_wdata,
   output logic rsp_valid,
   output logic [31:0] rsp_rdata,
   output logic [31:0] rsp_abort,
   output logic [7:0] error_summary
);
   typedef struct packed {
      didel_phase_t phase;
      logic [7:0] count;
      logic [31:0] rdata;
      logic [31:0] abort;
      logic mem_pending;
   } didel_state_t;

   didel_state_t st;
   didel_state_t next_st;
   logic [31:0] mem_rdata;
   logic [3:0] mem_sel;

   function automatic logic [7:0] motor_code(input didel_motors_t m);
      case (m)
         DIDEL_MOTORS_BLDC: motor_code = `DIDEL_MOTOR_BLDC; // RQ1
         DIDEL_MOTORS_STEPPER: motor_code = `DIDEL_MOTOR_STEPPER; // RQ1
         default: motor_code = `DIDEL_MOTOR_BOTH; // RQ1
      endcase
   endfunction : motor_code

   logic [31:0] identity_word;
   // constant word: fixed from start-up, nothing can alter it
   assign identity_word = {8'h00, motor_code(MOTORS), PROFILE}; // RQ1 RQ2

   didel_summary u_summary (
      .clk_sys(clk_sys),
      .arst_n(arst_n),
      .fault_active(fault_active),
      .summary(error_summary)
   );

   assign mem_sel = req_sub[3:0];

   didel_history_mem #(
      .DEPTH(DEPTH),
      .WIDTH(32)
   ) u_history (
      .clk_sys(clk_sys),
      .arst_n(arst_n),
      .push(fault_log), // RQ5
      .push_code(fault_code),
      .rd_sel(mem_sel),
      .rd_data(mem_rdata)
   );

   logic history_sub;
   assign history_sub = req_sub >= 8'h01 && 32'(req_sub) <= DEPTH;

   // zero written to the count restarts the log
   logic clear_now;
   assign clear_now = st.phase == DIDEL_IDLE && req_valid && req_write
      && req_index == `DIDEL_IDX_HISTORY && req_sub == 8'h00 && req_wdata == 32'h00000000;

   always_comb begin
      next_st = st;
      next_st.mem_pending = 1'b0;
      case (st.phase)
         DIDEL_IDLE: begin
            if (req_valid) begin
               next_st.phase = DIDEL_ANSWER;
               next_st.rdata = '0;
               next_st.abort = `DIDEL_ABORT_NONE;
               if (req_index == `DIDEL_IDX_IDENTITY) begin
                  if (req_write) begin
                     next_st.abort = `DIDEL_ABORT_READ_ONLY; // RQ12
                  end else if (req_sub != 8'h00) begin
                     next_st.abort = `DIDEL_ABORT_NO_SUB;
                  end else begin
                     next_st.rdata = identity_word; // RQ1 RQ2
                  end
               end else if (req_index == `DIDEL_IDX_SUMMARY) begin
                  if (req_write) begin
                     next_st.abort = `DIDEL_ABORT_READ_ONLY; // RQ12
                  end else if (req_sub != 8'h00) begin
                     next_st.abort = `DIDEL_ABORT_NO_SUB;
                  end else begin
                     next_st.rdata = {24'h000000, error_summary}; // RQ3
                  end
               end else if (req_index == `DIDEL_IDX_HISTORY) begin
                  if (req_sub == 8'h00) begin
                     if (!req_write) begin
                        next_st.rdata = {24'h000000, st.count}; // RQ8
                     end else if (req_wdata != 32'h00000000) begin
                        next_st.abort = `DIDEL_ABORT_BAD_VALUE; // RQ13
                     end
                  end else if (!history_sub) begin
                     next_st.abort = `DIDEL_ABORT_NO_SUB;
                  end else if (req_write) begin
                     next_st.abort = `DIDEL_ABORT_READ_ONLY; // RQ11 RQ12
                  end else if (st.count == 8'h00) begin
                     next_st.abort = `DIDEL_ABORT_NO_DATA; // RQ9
                  end else begin
                     // entry comes out of the memory register one cycle later
                     next_st.mem_pending = 1'b1; // RQ6
                  end
               end else begin
                  next_st.abort = `DIDEL_ABORT_NO_OBJECT;
               end
            end
         end
         DIDEL_ANSWER: begin
            next_st.phase = DIDEL_IDLE;
         end
         default: next_st.phase = DIDEL_IDLE;
      endcase
      // count: a clear and a new fault in the same cycle leave the count at one
      if (fault_log && clear_now) begin
         next_st.count = 8'h01; // RQ10
      end else if (fault_log) begin
         if (st.count < 8'(DEPTH)) begin
            next_st.count = st.count + 8'h01; // RQ8 RQ13
         end
      end else if (clear_now) begin
         next_st.count = `DIDEL_COUNT_RESET; // RQ10
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         st.phase <= DIDEL_IDLE;
         st.count <= `DIDEL_COUNT_RESET; // RQ11
         st.rdata <= '0;
         st.abort <= `DIDEL_ABORT_NONE;
         st.mem_pending <= 1'b0;
      end else begin
         st <= next_st;
      end
   end

   // requests taken only in idle; answer is a one-cycle pulse
   assign rsp_valid = st.phase == DIDEL_ANSWER;
   assign rsp_rdata = st.mem_pending ? mem_rdata : st.rdata;
   assign rsp_abort = st.abort;

   sequence take_read_s(logic [15:0] idx, logic [7:0] sub);
      st.phase == DIDEL_IDLE && req_valid && !req_write && req_index == idx && req_sub == sub;
   endsequence

   identity_read_a: assert property (@(posedge clk_sys) disable iff (!arst_n) // RQ1 RQ2
      take_read_s(16'h1000, 8'h00) |=> rsp_valid && rsp_rdata[23:16] == motor_code(MOTORS)
      && rsp_rdata[15:0] == PROFILE && rsp_abort == 32'h0)
      else $error("identity read wrong");
   count_read_a: assert property (@(posedge clk_sys) disable iff (!arst_n) // RQ8
      take_read_s(16'h1003, 8'h00) |=> rsp_rdata == {24'h0, $past(st.count)})
      else $error("count read wrong");
   summary_read_a: assert property (@(posedge clk_sys) disable iff (!arst_n) // RQ3
      take_read_s(16'h1001, 8'h00) |=> rsp_valid && rsp_abort == 32'h0
      && rsp_rdata == {24'h0, $past(error_summary)})
      else $error("summary read wrong");
   empty_abort_a: assert property (@(posedge clk_sys) disable iff (!arst_n) // RQ9
      (st.phase == DIDEL_IDLE && req_valid && !req_write && req_index == 16'h1003
      && req_sub == 8'h03 && st.count == 8'h00) |=> rsp_valid && rsp_abort == 32'h08000024)
      else $error("empty history read not aborted");
   count_clear_a: assert property (@(posedge clk_sys) disable iff (!arst_n) // RQ10
      clear_now && !fault_log |=> st.count == 8'h00)
      else $error("count not cleared");
   clear_log_a: assert property (@(posedge clk_sys) disable iff (!arst_n) // RQ10
      clear_now && fault_log |=> st.count == 8'h01)
      else $error("fault beside a clear not counted");
   count_sat_a: assert property (@(posedge clk_sys) disable iff (!arst_n) // RQ13
      st.count <= 8'h08)
      else $error("count above eight");
   count_hold_a: assert property (@(posedge clk_sys) disable iff (!arst_n) // RQ13
      fault_log && !clear_now && st.count == 8'h08 |=> st.count == 8'h08)
      else $error("count moved past full");
   count_step_a: assert property (@(posedge clk_sys) disable iff (!arst_n) // RQ5
      fault_log && !clear_now && st.count < 8'h08 |=> st.count == $past(st.count) + 8'h01)
      else $error("count did not step on fault");
   count_quiet_a: assert property (@(posedge clk_sys) disable iff (!arst_n) // RQ8
      !fault_log && !clear_now |=> $stable(st.count))
      else $error("count changed without a fault or clear");
   ro_write_a: assert property (@(posedge clk_sys) disable iff (!arst_n) // RQ12
      (st.phase == DIDEL_IDLE && req_valid && req_write
      && (req_index == 16'h1000 || req_index == 16'h1001)) |=> rsp_abort == 32'h06010002)
      else $error("read-only write accepted");
   entry_write_a: assert property (@(posedge clk_sys) disable iff (!arst_n) // RQ11
      (st.phase == DIDEL_IDLE && req_valid && req_write && req_index == 16'h1003
      && history_sub) |=> rsp_valid && rsp_abort == 32'h06010002)
      else $error("history entry write accepted");
   nonzero_write_a: assert property (@(posedge clk_sys) disable iff (!arst_n) // RQ13
      (st.phase == DIDEL_IDLE && req_valid && req_write && req_index == 16'h1003
      && req_sub == 8'h00 && req_wdata != 32'h0 && !fault_log)
      |=> rsp_valid && rsp_abort == 32'h06090030 && $stable(st.count))
      else $error("nonzero count write accepted");
   sub_range_a: assert property (@(posedge clk_sys) disable iff (!arst_n) // RQ6
      (st.phase == DIDEL_IDLE && req_valid && req_index == 16'h1003 && req_sub > 8'h08)
      |=> rsp_valid && rsp_abort == 32'h06090011)
      else $error("history position beyond eight accepted");
   entry_read_a: assert property (@(posedge clk_sys) disable iff (!arst_n) // RQ6
      (st.phase == DIDEL_IDLE && req_valid && !req_write && req_index == 16'h1003
      && req_sub == 8'h01 && st.count != 8'h00 && !fault_log) |=> rsp_valid
      && rsp_abort == 32'h0 && rsp_rdata == u_history.st.entry[0])
      else $error("entry read wrong");
endmodule : didel_top

// ===== rtl/didel_defs.svh
// object offsets, field positions, preset values and abort codes of the identity and fault log
`ifndef DIDEL_DEFS_SVH
`define DIDEL_DEFS_SVH
`define DIDEL_IDX_IDENTITY 16'h1000
`define DIDEL_IDX_SUMMARY 16'h1001
`define DIDEL_IDX_HISTORY 16'h1003
`define DIDEL_MOTOR_LSB 16
`define DIDEL_MOTOR_MSB 23
`define DIDEL_PROFILE_MSB 15
`define DIDEL_MOTOR_BLDC 8'h02
`define DIDEL_MOTOR_STEPPER 8'h04
`define DIDEL_MOTOR_BOTH 8'h06
// arbitrary profile number; each product sets its own through the parameter
`define DIDEL_PROFILE_DEFAULT 16'h5A3C
`define DIDEL_GENERAL_POS 0
`define DIDEL_CURRENT_POS 1
`define DIDEL_VOLTAGE_POS 2
`define DIDEL_TEMPERATURE_POS 3
`define DIDEL_COMM_POS 4
`define DIDEL_PROFILE_POS 5
`define DIDEL_RESERVED_POS 6
`define DIDEL_MAKER_POS 7
`define DIDEL_SUMMARY_MASK 8'hBF
`define DIDEL_SUMMARY_RESET 8'h00
`define DIDEL_COUNT_RESET 8'h00
`define DIDEL_ENTRY_RESET 32'h00000000
`define DIDEL_HISTORY_DEPTH 8
`define DIDEL_ABORT_NONE 32'h00000000
`define DIDEL_ABORT_NO_DATA 32'h08000024
`define DIDEL_ABORT_READ_ONLY 32'h06010002
`define DIDEL_ABORT_NO_OBJECT 32'h06020000
`define DIDEL_ABORT_NO_SUB 32'h06090011
`define DIDEL_ABORT_BAD_VALUE 32'h06090030
`endif

// ===== rtl/didel_pkg.sv
// types shared by the identity and fault log block
package didel_pkg;
   typedef enum logic [1:0] {
      DIDEL_MOTORS_BLDC,
      DIDEL_MOTORS_STEPPER,
      DIDEL_MOTORS_BOTH
   } didel_motors_t;
   typedef enum {
      DIDEL_IDLE,
      DIDEL_ANSWER
   } didel_phase_t;
endpackage : didel_pkg

// ===== rtl/didel_history_mem.sv
// eight-deep shifting fault history with registered read data
`timescale 1ns/1ps
`include "didel_defs.svh"
module didel_history_mem #(
   parameter int DEPTH = `DIDEL_HISTORY_DEPTH,
   parameter int WIDTH = 32
) (
   input wire logic clk_sys,
   input wire logic arst_n,
   input wire logic push,
   input wire logic [WIDTH-1:0] push_code,
   input wire logic [3:0] rd_sel,
   output logic [WIDTH-1:0] rd_data
);
   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] entry;
      logic [WIDTH-1:0] rd_data;
   } didel_mem_state_t;
   didel_mem_state_t st;
   didel_mem_state_t next_st;
   always_comb begin
      next_st = st;
      if (push) begin
         // newest at slot 0; oldest shifts out the far end
         next_st.entry[0] = push_code; // RQ7
         for (int i = 1; i < DEPTH; i++) begin
            next_st.entry[i] = st.entry[i-1]; // RQ7
         end
      end
      if (rd_sel >= 4'h1 && 32'(rd_sel) <= DEPTH) begin
         next_st.rd_data = st.entry[rd_sel - 4'h1]; // RQ6
      end else begin
         next_st.rd_data = '0;
      end
   end
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         st <= '0; // RQ11
      end else begin
         st <= next_st;
      end
   end
   assign rd_data = st.rd_data;
   shift_order_a: assert property (@(posedge clk_sys) disable iff (!arst_n) // RQ7
      push |=> st.entry[0] == $past(push_code) && st.entry[1] == $past(st.entry[0]))
      else $error("history did not shift on push");
   hold_quiet_a: assert property (@(posedge clk_sys) disable iff (!arst_n) // RQ6
      !push |=> $stable(st.entry))
      else $error("history changed without a push");
endmodule : didel_history_mem

// ===== rtl/didel_summary.sv
// fault category summary byte following live fault levels
`timescale 1ns/1ps
`include "didel_defs.svh"
module didel_summary (
   input wire logic clk_sys,
   input wire logic arst_n,
   input wire logic [7:0] fault_active,
   output logic [7:0] summary
);
   typedef struct packed {
      logic [7:0] summary;
   } didel_sum_state_t;
   didel_sum_state_t st;
   didel_sum_state_t next_st;
   always_comb begin
      next_st = st;
      // level-following: a bit falls by itself when its fault goes
      next_st.summary = fault_active & `DIDEL_SUMMARY_MASK; // RQ3 RQ4
   end
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         st.summary <= `DIDEL_SUMMARY_RESET;
      end else begin
         st <= next_st;
      end
   end
   assign summary = st.summary;
   // first edge after reset still shows the preset, not the fault levels
   follow_fault_a: assert property (@(posedge clk_sys) disable iff (!arst_n) // RQ3
      $past(arst_n) |-> summary == ($past(fault_active) & `DIDEL_SUMMARY_MASK))
      else $error("summary does not follow fault levels");
   reserved_zero_a: assert property (@(posedge clk_sys) disable iff (!arst_n) // RQ4
      summary[6] == 1'b0)
      else $error("reserved summary bit set");
endmodule : didel_summary

// ===== test/didel_master.sv
// network master model issuing one object access at a time
`timescale 1ns/1ps
module didel_master (
   input wire logic clk_sys,
   input wire logic rsp_valid,
   input wire logic [31:0] rsp_rdata,
   input wire logic [31:0] rsp_abort,
   output logic req_valid,
   output logic req_write,
   output logic [15:0] req_index,
   output logic [7:0] req_sub,
   output logic [31:0] req_wdata
);
   initial begin
      req_valid = 1'b0;
      req_write = 1'b0;
      req_index = 16'h0000;
      req_sub = 8'h00;
      req_wdata = 32'h00000000;
   end

   // one request, then wait a bounded number of edges for the answer pulse
   task automatic access(input logic wr, input logic [15:0] idx, input logic [7:0] sub,
         input logic [31:0] wd, output logic [31:0] rd, output logic [31:0] ab,
         output bit seen);
      seen = 1'b0;
      @(posedge clk_sys);
      req_valid <= 1'b1;
      req_write <= wr;
      req_index <= idx;
      req_sub <= sub;
      req_wdata <= wd;
      @(posedge clk_sys);
      // released lines go to the inverse so a stale request cannot pass for a live one
      req_valid <= 1'b0;
      req_write <= ~wr;
      req_index <= ~idx;
      req_sub <= ~sub;
      req_wdata <= ~wd;
      for (int n = 0; n < 4 && !seen; n++) begin
         @(posedge clk_sys);
         if (rsp_valid === 1'b1) begin
            seen = 1'b1;
            rd = rsp_rdata;
            ab = rsp_abort;
         end
      end
   endtask : access
endmodule : didel_master

// ===== test/tb_device_identity_error_log.sv
// self-checking bench for the identity, summary and fault history objects
`timescale 1ns/1ps
module tb_device_identity_error_log;
   import didel_pkg::*;
   logic clk_sys;
   logic arst_n;
   logic [7:0] fault_active;
   logic fault_log;
   logic [31:0] fault_code;
   logic req_valid, req_write, rsp_valid;
   logic [15:0] req_index;
   logic [7:0] req_sub, error_summary, v;
   logic [31:0] req_wdata, rsp_rdata, rsp_abort, code;
   logic [31:0] hist[$];
   int bad_count = 0;
   int samples_checked = 0;

   didel_top u_didel_top (.clk_sys(clk_sys), .arst_n(arst_n), .fault_active(fault_active),
      .fault_log(fault_log), .fault_code(fault_code), .req_valid(req_valid),
      .req_write(req_write), .req_index(req_index), .req_sub(req_sub),
      .req_wdata(req_wdata), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
      .rsp_abort(rsp_abort), .error_summary(error_summary));
   didel_master u_didel_master (.clk_sys(clk_sys), .rsp_valid(rsp_valid),
      .rsp_rdata(rsp_rdata), .rsp_abort(rsp_abort), .req_valid(req_valid),
      .req_write(req_write), .req_index(req_index), .req_sub(req_sub),
      .req_wdata(req_wdata));

   initial begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end

   task automatic print_verdict();
      $display("checked %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : print_verdict

   task automatic check_word(string what, logic [31:0] exp, logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         bad_count++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask : check_word

   task automatic check_byte(string what, logic [7:0] exp, logic [7:0] got);
      samples_checked++;
      if (got !== exp) begin
         bad_count++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask : check_byte

   // read data is only meaningful for reads that were not aborted
   task automatic acc(logic wr, logic [15:0] idx, logic [7:0] sub, logic [31:0] wd,
         logic [31:0] exp_rd, logic [31:0] exp_ab);
      logic [31:0] rd, ab;
      bit seen;
      u_didel_master.access(wr, idx, sub, wd, rd, ab, seen);
      if (!seen) begin
         bad_count++;
         $display("MISMATCH answer expected 1 seen 0");
         print_verdict();
      end else begin
         check_word("abort", exp_ab, ab);
         if (!wr && exp_ab == 32'h00000000) begin
            check_word("rdata", exp_rd, rd);
         end
      end
   endtask : acc

   task automatic log_fault();
      code = $urandom;
      @(posedge clk_sys);
      fault_log <= 1'b1;
      fault_code <= code;
      @(posedge clk_sys);
      fault_log <= 1'b0;
      hist.push_front(code);
      if (hist.size() > 8) begin
         void'(hist.pop_back());
      end
   endtask : log_fault

   initial begin
      arst_n = 1'b0;
      fault_active = 8'h00;
      fault_log = 1'b0;
      fault_code = 32'h00000000;
      void'($urandom(32'hB9DD57EC));
      repeat (16) @(posedge clk_sys);
      arst_n <= 1'b1;
      acc(1'b0, 16'h1000, 8'h00, 32'h0, {8'h00, 8'h06, 16'h5A3C}, 32'h0);
      acc(1'b0, 16'h1001, 8'h00, 32'h0, 32'h00000000, 32'h0);
      acc(1'b0, 16'h1003, 8'h00, 32'h0, 32'h00000000, 32'h0);
      for (int s = 1; s <= 8; s++) begin
         acc(1'b0, 16'h1003, 8'(s), 32'h0, 32'h0, 32'h08000024);
      end
      acc(1'b1, 16'h1000, 8'h00, $urandom, 32'h0, 32'h06010002);
      acc(1'b1, 16'h1001, 8'h00, $urandom, 32'h0, 32'h06010002);
      $display("test presets done");
      for (int i = 0; i < 13; i++) begin
         v = (i == 12) ? 8'h00 : ((i == 0) ? 8'hFF : 8'($urandom));
         @(posedge clk_sys);
         fault_active <= v;
         @(posedge clk_sys);
         @(posedge clk_sys);
         check_byte("summary", v & 8'hBF, error_summary);
         acc(1'b0, 16'h1001, 8'h00, 32'h0, {24'h0, v & 8'hBF}, 32'h0);
      end
      $display("test summary done");
      for (int i = 0; i < 10; i++) begin
         log_fault();
         acc(1'b0, 16'h1003, 8'h00, 32'h0, 32'(hist.size()), 32'h0);
         for (int s = 1; s <= hist.size(); s++) begin
            acc(1'b0, 16'h1003, 8'(s), 32'h0, hist[s-1], 32'h0);
         end
      end
      acc(1'b1, 16'h1003, 8'h02, $urandom, 32'h0, 32'h06010002);
      acc(1'b0, 16'h1003, 8'h09, 32'h0, 32'h0, 32'h06090011);
      $display("test history done");
      acc(1'b1, 16'h1003, 8'h00, 32'h00000003, 32'h0, 32'h06090030);
      acc(1'b0, 16'h1003, 8'h00, 32'h0, 32'h00000008, 32'h0);
      acc(1'b1, 16'h1003, 8'h00, 32'h00000000, 32'h0, 32'h0);
      hist.delete();
      acc(1'b0, 16'h1003, 8'h00, 32'h0, 32'h00000000, 32'h0);
      acc(1'b0, 16'h1003, 8'h01, 32'h0, 32'h0, 32'h08000024);
      log_fault();
      acc(1'b0, 16'h1003, 8'h00, 32'h0, 32'h00000001, 32'h0);
      acc(1'b0, 16'h1003, 8'h01, 32'h0, hist[0], 32'h0);
      // fault and zero write taken at the same edge: the fault is kept
      fork
         log_fault();
         acc(1'b1, 16'h1003, 8'h00, 32'h00000000, 32'h0, 32'h0);
      join
      while (hist.size() > 1) begin
         void'(hist.pop_back());
      end
      acc(1'b0, 16'h1003, 8'h00, 32'h0, 32'h00000001, 32'h0);
      acc(1'b0, 16'h1003, 8'h01, 32'h0, hist[0], 32'h0);
      $display("test clear done");
      // reset in mid-run with faults standing
      v = 8'($urandom) | 8'h01;
      @(posedge clk_sys);
      fault_active <= v;
      arst_n <= 1'b0;
      repeat (3) @(posedge clk_sys);
      arst_n <= 1'b1;
      hist.delete();
      acc(1'b0, 16'h1003, 8'h00, 32'h0, 32'h00000000, 32'h0);
      acc(1'b0, 16'h1003, 8'h01, 32'h0, 32'h0, 32'h08000024);
      acc(1'b0, 16'h1001, 8'h00, 32'h0, {24'h0, v & 8'hBF}, 32'h0);
      $display("test reset done");
      print_verdict();
   end
endmodule : tb_device_identity_error_log
